// ### clock_output_control_pkg.sv
// constants and carrier types for the clock output control block
package clock_output_control_pkg;

  // timing
  localparam int unsigned CLK_HZ            = 10_000_000;
  localparam int unsigned STRAP_WINDOW_US   = 2000;       // 2 ms strap window
  localparam int unsigned STRAP_WINDOW_CYC  =
    (STRAP_WINDOW_US * (CLK_HZ / 1_000_000));
  localparam int unsigned PD_SAMPLES        = 2;          // consecutive low samples

  // register byte addresses
  localparam logic [3:0] ADDR_CTRL0   = 4'h0;  // serial byte 0 image
  localparam logic [3:0] ADDR_FSEL    = 4'h4;  // frequency override
  localparam logic [3:0] ADDR_STATUS  = 4'h8;  // block state
  localparam logic [3:0] ADDR_SPREAD  = 4'hC;  // spread and video mode

  // field positions
  localparam int unsigned CTRL0_SPREAD_BIT  = 3;
  localparam int unsigned FSEL_LO_BIT       = 0;
  localparam int unsigned FSEL_HI_BIT       = 1;
  localparam int unsigned FSEL_OVR_BIT      = 2;
  localparam int unsigned SPREAD_CENTRE_BIT = 0;
  localparam int unsigned SPREAD_VIDEO_BIT  = 1;

  // reset values
  localparam logic [7:0] CTRL0_RESET  = 8'h00;
  localparam logic [2:0] FSEL_RESET   = 3'h0;
  localparam logic [1:0] SPREAD_RESET = 2'h0;

  // axi responses
  localparam logic [1:0] RESP_OKAY   = 2'h0;
  localparam logic [1:0] RESP_SLVERR = 2'h2;

  // frequency selection codes {hi, lo}
  typedef enum logic [1:0] {
    FSEL_66_100  = 2'h0,
    FSEL_100_100 = 2'h1,
    FSEL_133_133 = 2'h2,
    FSEL_133_100 = 2'h3
  } fsel_type;

  // processor / memory rates in MHz
  typedef struct packed {
    logic [7:0] proc_mhz;
    logic [7:0] mem_mhz;
  } rate_pair_type;

  // sequencer states
  typedef enum logic [3:0] {
    ST_SAMPLE = 4'h1,
    ST_RUN    = 4'h2,
    ST_DOWN   = 4'h4,
    ST_WAKE   = 4'h8
  } seq_state_type;

  // stop / power-down inputs as a group
  typedef struct packed {
    logic power_down_n;
    logic processor_stop_n;
    logic periph_stop_n;
  } ctrl_in_type;

  // clock-enable outputs toward the output buffers
  typedef struct packed {
    logic       proc_gated_en;
    logic       proc_free_en;
    logic       mem_en;
    logic       memory_hub_clk_en;
    logic [5:0] periph_gated_en;
    logic       periph_free_en;
    logic       intr_ctrl_clk_en;
    logic       hub_66m_clk_en;
    logic       fixed_48m_en;
    logic       video_hub_clk_en;
  } clk_en_type;

  // strap pin as a tri-state pair
  typedef struct packed {
    logic o;
    logic oe;
  } pin_drive_type;

endpackage

// ### clock_output_control.sv
// clock output control: strap sampling, gating, power-down and spread control
//
// Behaviour
// [RULE1] first 2 ms after supply-good sample straps, strap pin buffers off
// [RULE2] at window end latch strap levels, then enable strap pin buffers
// [RULE3] window timer starts when supply-detect says 3.3 V rail reached 2.0 V
// [RULE4] latched straps kept until supply cycles; nothing else clears them
// [RULE5] pin low latches 0, pin high latches 1
// [RULE6] select 00:66/100, 01:100/100, 10:133/133, 11:133/100 MHz
// [RULE7] frequency selection may instead come from serial configuration
// [RULE8] 48 MHz usb and dot outputs fixed, never spread
// [RULE9] interrupt-controller clock fixed 33.3 MHz, synchronous to processor clock
// [RULE10] processor stop low halts only gated processor clock, held low
// [RULE11] peripheral stop low halts six gated peripheral clocks, free one runs
// [RULE12] memory hub clock free-running, never gated by stops
// [RULE13] power-down low: synthesizers off, every clock output low
// [RULE14] power-down input synchronised before use
// [RULE15] two consecutive low samples, then outputs held low at next falling edge
// [RULE16] at 100 MHz processor clock is inverted relative to memory clocks
// [RULE17] spread on or off from bit 3 of first serial data byte
// [RULE18] spread deviation centre plus-minus 0.5 or down minus 0.5 percent
// [RULE19] video hub clock 48 MHz unmodulated or 66.67 MHz spread
// [RULE20] one short processor cycle allowed when outputs first enabled
// [RULE21] spread bit 1 turns modulation on, 0 turns it off
// [RULE22] serial controller writes bytes ascending from lowest, no indexing
// [RULE23] stop inputs synchronised, gating changes only while clock low
// [RULE24] power-down release restarts cleanly without re-sampling straps
//
// The register addresses and the AXI4-Lite interface to the registers were chosen for this implementation.
`timescale 1ns/1ps

module clock_output_control
  import clock_output_control_pkg::*;
#(
  parameter int unsigned STRAP_CYCLES = STRAP_WINDOW_CYC
) (
  input  wire logic        aclk,
  input  wire logic        aresetn,
  // supply and strap pins
  input  wire logic        supply_good,
  input  wire logic        freq_select_lo_i,
  output      logic        freq_select_lo_o,
  output      logic        freq_select_lo_oe,
  input  wire logic        freq_select_hi_i,
  output      logic        freq_select_hi_o,
  output      logic        freq_select_hi_oe,
  // output clock phases (processor and peripheral clock levels from the synthesizer) and stop inputs
  input  wire logic        proc_clk_level,
  input  wire logic        periph_clk_level,
  input  wire ctrl_in_type ctrl_in,
  // outputs toward the synthesizer and buffers
  output      clk_en_type  clk_en,
  output      logic        synth_on,
  output      logic        spread_on,
  output      logic        spread_centre,
  output      logic        video_hub_66m,
  output      logic        proc_invert,
  output      rate_pair_type rate,
  // axi4-lite slave
  input  wire logic [3:0]  s_axi_awaddr,
  input  wire logic        s_axi_awvalid,
  output      logic        s_axi_awready,
  input  wire logic [31:0] s_axi_wdata,
  input  wire logic [3:0]  s_axi_wstrb,
  input  wire logic        s_axi_wvalid,
  output      logic        s_axi_wready,
  output      logic [1:0]  s_axi_bresp,
  output      logic        s_axi_bvalid,
  input  wire logic        s_axi_bready,
  input  wire logic [3:0]  s_axi_araddr,
  input  wire logic        s_axi_arvalid,
  output      logic        s_axi_arready,
  output      logic [31:0] s_axi_rdata,
  output      logic [1:0]  s_axi_rresp,
  output      logic        s_axi_rvalid,
  input  wire logic        s_axi_rready
);

  // whole block state
  typedef struct packed {
    seq_state_type state;
    logic [31:0]   win_cnt;
    logic          strap_lo;
    logic          strap_hi;
    logic          strap_valid;
    logic          pins_on;
    logic [7:0]    ctrl0;
    logic [2:0]    fsel;
    logic [1:0]    spread;
    logic [1:0]    pd_sync;
    logic [1:0]    ps_sync;
    logic [1:0]    pp_sync;
    logic [1:0]    pd_low_cnt;
    logic          proc_lvl_d;
    logic          proc_gate;
    logic          periph_gate;
    logic          out_on;
    logic          aw_held;
    logic [3:0]    aw_addr;
    logic          w_held;
    logic [31:0]   w_data;
    logic [3:0]    w_strb;
    logic          bvalid;
    logic [1:0]    bresp;
    logic          rvalid;
    logic [31:0]   rdata;
    logic [1:0]    rresp;
  } state_type;

  state_type s_reg;
  state_type s_next;
  fsel_type  fsel_eff;
  logic      wr_go;
  logic      rd_go;
  logic      proc_fall;
  pin_drive_type lo_drv;
  pin_drive_type hi_drv;

  // write address and data taken independently, response after both
  assign s_axi_awready = !s_reg.aw_held && !s_reg.bvalid;
  assign s_axi_wready  = !s_reg.w_held && !s_reg.bvalid;
  assign s_axi_arready = !s_reg.rvalid;
  assign wr_go         = s_reg.aw_held && s_reg.w_held && !s_reg.bvalid;
  assign rd_go         = s_axi_arvalid && s_axi_arready;
  assign proc_fall     = s_reg.proc_lvl_d && !proc_clk_level;

  // effective select: software override wins once set
  always_comb begin
    if (s_reg.fsel[FSEL_OVR_BIT]) begin
      fsel_eff = fsel_type'({s_reg.fsel[FSEL_HI_BIT], s_reg.fsel[FSEL_LO_BIT]}); // [RULE7]
    end else begin
      fsel_eff = fsel_type'({s_reg.strap_hi, s_reg.strap_lo}); // [RULE6]
    end
  end

  always_comb begin
    s_next = s_reg;

    // synchronisers, first stage only feeds second
    s_next.pd_sync = {s_reg.pd_sync[0], ctrl_in.power_down_n}; // [RULE14]
    s_next.ps_sync = {s_reg.ps_sync[0], ctrl_in.processor_stop_n};
    s_next.pp_sync = {s_reg.pp_sync[0], ctrl_in.periph_stop_n};
    s_next.proc_lvl_d = proc_clk_level;

    // power-down counted on processor rising edges
    if (!s_reg.proc_lvl_d && proc_clk_level) begin
      if (!s_reg.pd_sync[1]) begin
        if (s_reg.pd_low_cnt != 2'(PD_SAMPLES)) begin
          s_next.pd_low_cnt = s_reg.pd_low_cnt + 2'h1; // [RULE15]
        end
      end else begin
        s_next.pd_low_cnt = 2'h0;
      end
    end

    // window, run, power-down and wake sequencing
    case (s_reg.state)
      ST_SAMPLE: begin
        s_next.pins_on = 1'b0; // [RULE1]
        if (!supply_good) begin
          s_next.win_cnt = 32'h0; // [RULE3]
        end else if (s_reg.win_cnt >= STRAP_CYCLES - 1) begin
          if (!s_reg.strap_valid) begin
            s_next.strap_lo    = freq_select_lo_i; // [RULE5]
            s_next.strap_hi    = freq_select_hi_i;
            s_next.strap_valid = 1'b1; // [RULE2]
          end else begin
            // buffers only once the latch already holds
            s_next.pins_on = 1'b1; // [RULE2]
            s_next.out_on  = 1'b1; // [RULE20]
            s_next.state   = ST_RUN;
          end
        end else begin
          s_next.win_cnt = s_reg.win_cnt + 32'h1;
        end
      end
      ST_RUN: begin
        if (s_reg.pd_low_cnt == 2'(PD_SAMPLES) && proc_fall) begin
          s_next.out_on = 1'b0; // [RULE15]
          s_next.state  = ST_DOWN;
        end
      end
      ST_DOWN: begin
        s_next.out_on = 1'b0; // [RULE13]
        // synthesizers stay off until the synchronised input reads high
        if (s_reg.pd_sync[1]) begin
          s_next.state = ST_WAKE; // [RULE24]
        end
      end
      ST_WAKE: begin
        // re-enable on a falling edge so the first pulse is whole
        if (!s_reg.pd_sync[1]) begin
          s_next.state = ST_DOWN;
        end else if (proc_fall) begin
          s_next.out_on = 1'b1; // [RULE24]
          s_next.state  = ST_RUN;
        end
      end
      default: begin
        s_next.state = ST_SAMPLE;
      end
    endcase

    // loss of supply restarts the window and clears outputs and strap_valid; registers keep values
    if (!supply_good) begin
      s_next.state       = ST_SAMPLE;
      s_next.strap_valid = 1'b0; // [RULE4]
      s_next.pins_on     = 1'b0;
      s_next.out_on      = 1'b0;
      s_next.pd_low_cnt  = 2'h0;
      // a one-cycle dip must restart the window, not skip it
      s_next.win_cnt     = 32'h0; // [RULE3]
    end

    // stop gating only changes while the clock is low
    if (!proc_clk_level) begin
      s_next.proc_gate = s_reg.ps_sync[1]; // [RULE23]
    end
    if (!periph_clk_level) begin
      s_next.periph_gate = s_reg.pp_sync[1]; // [RULE23]
    end

    // axi write capture
    // only byte lane 0 carries register bits; upper lanes are ignored
    if (s_axi_awvalid && s_axi_awready) begin
      s_next.aw_held = 1'b1;
      s_next.aw_addr = s_axi_awaddr;
    end
    if (s_axi_wvalid && s_axi_wready) begin
      s_next.w_held = 1'b1;
      s_next.w_data = s_axi_wdata;
      s_next.w_strb = s_axi_wstrb;
    end
    if (wr_go) begin
      s_next.aw_held = 1'b0;
      s_next.w_held  = 1'b0;
      s_next.bvalid  = 1'b1;
      s_next.bresp   = RESP_OKAY;
      case (s_reg.aw_addr)
        ADDR_CTRL0: begin
          if (s_reg.w_strb[0]) begin
            s_next.ctrl0 = s_reg.w_data[7:0]; // [RULE17]
          end
        end
        ADDR_FSEL: begin
          if (s_reg.w_strb[0]) begin
            s_next.fsel = s_reg.w_data[2:0]; // [RULE7]
          end
        end
        ADDR_SPREAD: begin
          if (s_reg.w_strb[0]) begin
            s_next.spread = s_reg.w_data[1:0];
          end
        end
        ADDR_STATUS: begin
          s_next.bresp = RESP_OKAY; // read-only, write ignored
        end
        default: begin
          s_next.bresp = RESP_SLVERR;
        end
      endcase
    end
    if (s_reg.bvalid && s_axi_bready) begin
      s_next.bvalid = 1'b0;
    end

    // axi read
    if (rd_go) begin
      s_next.rvalid = 1'b1;
      s_next.rresp  = RESP_OKAY;
      s_next.rdata  = 32'h0;
      case (s_axi_araddr)
        ADDR_CTRL0: begin
          s_next.rdata[7:0] = s_reg.ctrl0;
        end
        ADDR_FSEL: begin
          s_next.rdata[2:0] = s_reg.fsel;
        end
        ADDR_SPREAD: begin
          s_next.rdata[1:0] = s_reg.spread;
        end
        ADDR_STATUS: begin
          // nine bits: state code above the five strap and output flags
          s_next.rdata[8:0] = {s_reg.state, s_reg.out_on, s_reg.pins_on,
                               s_reg.strap_valid, s_reg.strap_hi, s_reg.strap_lo};
        end
        default: begin
          s_next.rresp = RESP_SLVERR;
        end
      endcase
    end else if (s_reg.rvalid && s_axi_rready) begin
      s_next.rvalid = 1'b0;
    end
  end

  // single state register
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      s_reg             <= '0;
      // straps survive reset; only a supply cycle may clear or re-take them
      s_reg.strap_lo    <= s_reg.strap_lo; // [RULE4]
      s_reg.strap_hi    <= s_reg.strap_hi;
      s_reg.strap_valid <= s_reg.strap_valid;
      s_reg.state       <= ST_SAMPLE;
      s_reg.ctrl0       <= CTRL0_RESET;
      s_reg.fsel        <= FSEL_RESET;
      s_reg.spread      <= SPREAD_RESET;
      s_reg.pd_sync     <= 2'h3;
      s_reg.ps_sync     <= 2'h3;
      s_reg.pp_sync     <= 2'h3;
      s_reg.proc_gate   <= 1'b1;
      s_reg.periph_gate <= 1'b1;
    end else begin
      s_reg <= s_next;
    end
  end

  // strap pins: released during the window, then driven as clocks;
  // power-down keeps the buffers on and drives them low instead of floating
  always_comb begin
    lo_drv    = '0;
    hi_drv    = '0;
    lo_drv.oe = s_reg.pins_on; // [RULE1] [RULE2]
    hi_drv.oe = s_reg.pins_on;
    lo_drv.o  = periph_clk_level && s_reg.out_on; // [RULE13]
    hi_drv.o  = periph_clk_level && s_reg.out_on && s_reg.periph_gate; // [RULE11]
  end

  assign freq_select_lo_o  = lo_drv.o;
  assign freq_select_lo_oe = lo_drv.oe;
  assign freq_select_hi_o  = hi_drv.o;
  assign freq_select_hi_oe = hi_drv.oe;

  // rate table
  // rates in MHz; the synthesizer works out its own dividers
  always_comb begin
    case (fsel_eff)
      FSEL_66_100:  rate = '{proc_mhz: 8'h42, mem_mhz: 8'h64}; // [RULE6]
      FSEL_100_100: rate = '{proc_mhz: 8'h64, mem_mhz: 8'h64};
      FSEL_133_133: rate = '{proc_mhz: 8'h85, mem_mhz: 8'h85};
      FSEL_133_100: rate = '{proc_mhz: 8'h85, mem_mhz: 8'h64};
      default:      rate = '{proc_mhz: 8'h42, mem_mhz: 8'h64};
    endcase
  end

  // synthesizer and modulation controls
  assign synth_on      = s_reg.out_on; // [RULE13]
  assign spread_on     = s_reg.ctrl0[CTRL0_SPREAD_BIT]; // [RULE17] [RULE21]
  assign spread_centre = s_reg.spread[SPREAD_CENTRE_BIT]; // [RULE18]
  assign video_hub_66m = s_reg.spread[SPREAD_VIDEO_BIT]; // [RULE19]
  assign proc_invert   = (fsel_eff == FSEL_100_100); // [RULE16]

  // output enables; fixed-rate groups follow only power state
  // spread and stop controls never reach the 48 MHz groups
  always_comb begin
    clk_en                   = '0;
    clk_en.proc_gated_en     = s_reg.out_on && s_reg.proc_gate; // [RULE10]
    clk_en.proc_free_en      = s_reg.out_on;
    clk_en.mem_en            = s_reg.out_on;
    clk_en.memory_hub_clk_en = s_reg.out_on; // [RULE12]
    clk_en.periph_gated_en   = {6{s_reg.out_on && s_reg.periph_gate}}; // [RULE11]
    clk_en.periph_free_en    = s_reg.out_on;
    clk_en.intr_ctrl_clk_en  = s_reg.out_on; // [RULE9]
    clk_en.hub_66m_clk_en    = s_reg.out_on;
    clk_en.fixed_48m_en      = s_reg.out_on; // [RULE8]
    clk_en.video_hub_clk_en  = s_reg.out_on;
  end

  assign s_axi_bvalid = s_reg.bvalid;
  assign s_axi_bresp  = s_reg.bresp;
  assign s_axi_rvalid = s_reg.rvalid;
  assign s_axi_rdata  = s_reg.rdata;
  assign s_axi_rresp  = s_reg.rresp;

endmodule // clock_output_control

// ### clock_output_control_properties.sv
// port checker for strap window, gating and power-down behaviour
`timescale 1ns/1ps
module clock_output_control_properties
  import clock_output_control_pkg::*;
#(
  parameter int unsigned STRAP_CYCLES = STRAP_WINDOW_CYC
) (
  input wire logic          aclk,
  input wire logic          aresetn,
  input wire logic          supply_good,
  input wire logic          freq_select_lo_oe,
  input wire logic          freq_select_hi_oe,
  input wire logic          proc_clk_level,
  input wire ctrl_in_type   ctrl_in,
  input wire clk_en_type    clk_en,
  input wire logic          synth_on,
  input wire logic          proc_invert,
  input wire rate_pair_type rate
);
  default clocking @(posedge aclk); endclocking
  default disable iff (!aresetn);
  logic [15:0] up_reg;
  logic [15:0] up_next;
  // cycles of good supply, saturating so a long run cannot wrap
  always_comb up_next = !supply_good ? 16'h0 : up_reg + 16'(up_reg != 16'hFFFF);
  always_ff @(posedge aclk) up_reg <= aresetn ? up_next : 16'h0;
  // stop inputs held long enough to pass the synchroniser and a low phase
  sequence s_proc_stop; (!ctrl_in.processor_stop_n && synth_on)[*6]; endsequence
  sequence s_periph_stop; (!ctrl_in.periph_stop_n && synth_on)[*6]; endsequence
  AST_WINDOW_OE_OFF: assert property (!supply_good |=> !freq_select_lo_oe && !freq_select_hi_oe)
    else $error("strap pin driven without good supply");
  AST_OE_AFTER_WINDOW: assert property ($rose(freq_select_lo_oe) |-> up_reg >= 16'(STRAP_CYCLES - 1))
    else $error("strap pin driven before window end");
  AST_PD_ALL_LOW: assert property (!synth_on |-> clk_en == '0)
    else $error("clock enabled while synthesizers off");
  AST_PD_SYNC: assert property ($fell(synth_on) && supply_good |-> $past(!ctrl_in.power_down_n, 3))
    else $error("power-down acted too early");
  AST_PROC_STOP_LOW: assert property (s_proc_stop |-> !clk_en.proc_gated_en)
    else $error("gated processor clock not stopped");
  AST_PERIPH_STOP_LOW: assert property (s_periph_stop |-> clk_en.periph_gated_en == 6'h00 && clk_en.periph_free_en)
    else $error("peripheral clocks not stopped correctly");
  AST_FREE_RUN: assert property (synth_on |-> clk_en.memory_hub_clk_en && clk_en.proc_free_en && clk_en.mem_en && clk_en.intr_ctrl_clk_en && clk_en.fixed_48m_en)
    else $error("free-running clock stopped");
  AST_GATE_LOW_PHASE: assert property (synth_on && $past(synth_on) && $changed(clk_en.proc_gated_en) |-> !$past(proc_clk_level))
    else $error("processor gate changed in high phase");
  AST_INVERT_RATE: assert property (proc_invert |-> rate == {8'h64, 8'h64})
    else $error("inversion outside 100 MHz mode");
endmodule // clock_output_control_properties

bind clock_output_control clock_output_control_properties #(.STRAP_CYCLES(STRAP_CYCLES)) i_props (
  .aclk, .aresetn, .supply_good, .freq_select_lo_oe, .freq_select_hi_oe, .proc_clk_level,
  .ctrl_in, .clk_en, .synth_on, .proc_invert, .rate);

// ### clock_load_model.sv
// clock phase source and strap resistors seen at the block's pins
`timescale 1ns/1ps
module clock_load_model (
  input  wire logic aclk,
  input  wire logic strap_lo,
  input  wire logic strap_hi,
  input  wire logic lo_o,
  input  wire logic lo_oe,
  input  wire logic hi_o,
  input  wire logic hi_oe,
  output logic      lo_pin,
  output logic      hi_pin,
  output logic      proc_lvl,
  output logic      periph_lvl
);
  logic [1:0] ph_reg = 2'h0;
  // phase keeps running so gating can always find a low phase
  always @(posedge aclk) ph_reg <= ph_reg + 2'h1;
  assign proc_lvl   = ph_reg[0];
  assign periph_lvl = ph_reg[1];
  // a released pin settles at its resistor level
  assign lo_pin = lo_oe ? lo_o : strap_lo;
  assign hi_pin = hi_oe ? hi_o : strap_hi;
endmodule // clock_load_model

// ### tb.sv
// self-checking bench for the clock output control block
`timescale 1ns/1ps
module tb;
  import clock_output_control_pkg::*;
  localparam int unsigned STRAPS = 20;
  typedef struct packed { logic [1:0] resp; logic [31:0] data; logic [31:0] mask; } note_type;
  logic aclk = 0, aresetn = 0, supply_good = 0, strap_lo = 0, strap_hi = 0;
  logic freq_select_lo_i, freq_select_lo_o, freq_select_lo_oe, proc_clk_level;
  logic freq_select_hi_i, freq_select_hi_o, freq_select_hi_oe, periph_clk_level;
  logic synth_on, spread_on, spread_centre, video_hub_66m, proc_invert;
  logic s_axi_awvalid = 0, s_axi_wvalid = 0, s_axi_bready = 0, s_axi_arvalid = 0, s_axi_rready = 0;
  logic s_axi_awready, s_axi_wready, s_axi_bvalid, s_axi_arready, s_axi_rvalid;
  logic [3:0] s_axi_awaddr = 0, s_axi_araddr = 0;
  logic [31:0] s_axi_wdata = 0, s_axi_rdata, lfsr = 32'h32B790E4;
  logic [1:0] s_axi_bresp, s_axi_rresp;
  ctrl_in_type ctrl_in = 3'h7;
  clk_en_type clk_en;
  rate_pair_type rate;
  note_type notes[$];
  int err_total = 0, comparisons = 0, cycles = 0;

  always #50 aclk = ~aclk;
  clock_output_control #(.STRAP_CYCLES(STRAPS)) i_dut (.aclk, .aresetn, .supply_good,
    .freq_select_lo_i, .freq_select_lo_o, .freq_select_lo_oe, .freq_select_hi_i,
    .freq_select_hi_o, .freq_select_hi_oe, .proc_clk_level, .periph_clk_level, .ctrl_in,
    .clk_en, .synth_on, .spread_on, .spread_centre, .video_hub_66m, .proc_invert, .rate,
    .s_axi_awaddr, .s_axi_awvalid, .s_axi_awready, .s_axi_wdata, .s_axi_wstrb(4'hF),
    .s_axi_wvalid, .s_axi_wready, .s_axi_bresp, .s_axi_bvalid, .s_axi_bready, .s_axi_araddr,
    .s_axi_arvalid, .s_axi_arready, .s_axi_rdata, .s_axi_rresp, .s_axi_rvalid, .s_axi_rready);
  clock_load_model i_load (.aclk, .strap_lo, .strap_hi, .lo_o(freq_select_lo_o),
    .lo_oe(freq_select_lo_oe), .hi_o(freq_select_hi_o), .hi_oe(freq_select_hi_oe),
    .lo_pin(freq_select_lo_i), .hi_pin(freq_select_hi_i), .proc_lvl(proc_clk_level),
    .periph_lvl(periph_clk_level));

  function automatic logic [31:0] lfsr_next(input logic [31:0] x);
    return {x[30:0], x[31] ^ x[21] ^ x[1] ^ x[0]};
  endfunction
  function automatic logic [31:0] exp_rate(input logic [1:0] c);
    return (c == 2'h0) ? 32'h4264 : (c == 2'h1) ? 32'h6464 : (c == 2'h2) ? 32'h8585 : 32'h8564;
  endfunction
  task automatic check(input logic [31:0] seen, input logic [31:0] exp);
    comparisons++;
    if (seen !== exp) begin
      err_total++;
      $display("[ERR] t=%0t seen=%h exp=%h", $time, seen, exp);
    end
  endtask
  task automatic report_and_stop;
    $display("mismatches=%0d comparisons=%0d", err_total, comparisons);
    if (err_total == 0 && comparisons > 0) $display("Test passed");
    else $display("Test failed");
    $finish;
  endtask
  // a hang counts as a mismatch
  always @(posedge aclk) begin
    cycles++;
    if (cycles == 5000) begin
      err_total++;
      report_and_stop();
    end
  end
  // read results are matched against the oldest note
  always @(posedge aclk) begin : mon
    note_type n;
    if (s_axi_rvalid && s_axi_rready) begin
      n = notes.pop_front();
      check(32'(s_axi_rresp), 32'(n.resp));
      check(s_axi_rdata & n.mask, n.data);
    end
  end
  task automatic axi_wr(input logic [3:0] a, input logic [31:0] d, input logic [1:0] er);
    logic aw_ok, w_ok;
    aw_ok = 0;
    w_ok = 0;
    s_axi_awaddr <= a;
    s_axi_wdata <= d;
    s_axi_awvalid <= 1;
    s_axi_wvalid <= 1;
    s_axi_bready <= 1;
    while (!(aw_ok && w_ok)) begin
      @(posedge aclk);
      if (s_axi_awvalid && s_axi_awready) begin aw_ok = 1; s_axi_awvalid <= 0; end
      if (s_axi_wvalid && s_axi_wready) begin w_ok = 1; s_axi_wvalid <= 0; end
    end
    while (!s_axi_bvalid) @(posedge aclk);
    s_axi_bready <= 0;
    check(32'(s_axi_bresp), 32'(er));
    @(posedge aclk);
  endtask
  task automatic axi_rd(input logic [3:0] a, input logic [31:0] d, input logic [31:0] m,
                        input logic [1:0] er);
    notes.push_back('{er, d, m});
    s_axi_araddr <= a;
    s_axi_arvalid <= 1;
    do @(posedge aclk); while (!s_axi_arready);
    s_axi_arvalid <= 0;
    s_axi_rready <= 1;
    do @(posedge aclk); while (!s_axi_rvalid);
    s_axi_rready <= 0;
    @(posedge aclk);
  endtask
  task automatic power_up(input logic [1:0] c);
    supply_good <= 0;
    strap_lo <= c[0];
    strap_hi <= c[1];
    repeat (3) @(posedge aclk);
    supply_good <= 1;
    repeat (STRAPS / 2) @(posedge aclk);
    check(32'({freq_select_lo_oe, freq_select_hi_oe}), 32'h0);
    for (int i = 0; i < 40 && !freq_select_lo_oe; i++) @(posedge aclk);
    check(32'(freq_select_lo_oe), 32'h1);
  endtask

  // main sequence
  initial begin
    repeat (20) @(posedge aclk);
    aresetn <= 1;
    @(posedge aclk);
    for (int c = 0; c < 4; c++) begin
      power_up(c[1:0]);
      check(32'(rate), exp_rate(c[1:0]));
      check(32'(proc_invert), 32'(c == 1));
      axi_rd(ADDR_STATUS, {27'h0, 3'h7, c[1:0]}, 32'h1F, RESP_OKAY);
    end
    // pins move after latching; the latched code must not follow
    strap_lo <= 0;
    strap_hi <= 0;
    axi_rd(ADDR_STATUS, 32'h1F, 32'h1F, RESP_OKAY);
    // mid-run reset: window runs again with pins released, straps are kept
    aresetn <= 0;
    repeat (2) @(posedge aclk);
    aresetn <= 1;
    @(posedge aclk);
    check(32'({freq_select_lo_oe, freq_select_lo_i}), 32'h0);
    for (int i = 0; i < 40 && !freq_select_lo_oe; i++) @(posedge aclk);
    check(32'(freq_select_lo_oe), 32'h1);
    check(32'(rate), exp_rate(2'h3));
    axi_rd(ADDR_STATUS, 32'h1F, 32'h1F, RESP_OKAY);
    repeat (4) begin
      lfsr = lfsr_next(lfsr);
      axi_wr(ADDR_FSEL, {30'h1, lfsr[1:0]}, RESP_OKAY);
      check(32'(rate), exp_rate(lfsr[1:0]));
      axi_rd(ADDR_FSEL, {30'h1, lfsr[1:0]}, 32'h7, RESP_OKAY);
    end
    axi_wr(ADDR_FSEL, 32'h0, RESP_OKAY);
    for (int s = 0; s < 4; s++) begin
      axi_wr(ADDR_CTRL0, {28'h0, s[0], 3'h0}, RESP_OKAY);
      axi_wr(ADDR_SPREAD, {30'h0, s[1:0]}, RESP_OKAY);
      check(32'(spread_on), 32'(s[0]));
      check(32'({video_hub_66m, spread_centre}), 32'(s[1:0]));
    end
    axi_rd(4'h2, 32'h0, 32'hFFFFFFFF, RESP_SLVERR);
    ctrl_in.processor_stop_n <= 0;
    repeat (10) @(posedge aclk);
    check(32'({clk_en.proc_gated_en, clk_en.memory_hub_clk_en}), 32'h1);
    ctrl_in.processor_stop_n <= 1;
    ctrl_in.periph_stop_n <= 0;
    repeat (10) @(posedge aclk);
    check(32'({clk_en.periph_gated_en, clk_en.periph_free_en, freq_select_hi_o}), 32'h02);
    ctrl_in.periph_stop_n <= 1;
    repeat (10) @(posedge aclk);
    check(32'({clk_en.proc_gated_en, clk_en.periph_gated_en}), 32'h7F);
    ctrl_in.power_down_n <= 0;
    repeat (12) @(posedge aclk);
    check(32'({synth_on, clk_en, freq_select_lo_o, freq_select_hi_o, freq_select_lo_oe}), 32'h1);
    ctrl_in.power_down_n <= 1;
    for (int i = 0; i < 20 && !synth_on; i++) @(posedge aclk);
    check(32'(synth_on), 32'h1);
    axi_rd(ADDR_STATUS, 32'h1F, 32'h1F, RESP_OKAY);
    report_and_stop();
  end
endmodule // tb
